// ==== include/irf_map.vh ====
// Constants for the infrared frame formatter: timing in base periods,
// frame layout and output packing.
// Assumes a single core clock whose period is given here in ns.
`ifndef IRF_MAP_VH
`define IRF_MAP_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IRF_CLK_NS        25
`define IRF_BASE_T_NS     436000
`define IRF_UNIT_W        4
`define IRF_UNIT_SAT      4'hf
`define IRF_SYNC_LO       4'h7
`define IRF_SYNC_HI       4'h9
`define IRF_ON_LO         4'h1
`define IRF_ON_HI         4'h3
`define IRF_ZERO_LO       4'h1
`define IRF_ZERO_HI       4'h3
`define IRF_ONE_LO        4'h5
`define IRF_ONE_HI        4'h7
`define IRF_FRAME_T       240
`define IRF_FRAME_TOL     8
`define IRF_GAP_W         9

// ------------------------------------------------------------
// Complemented-code frame layout, first received bit at the top
// ------------------------------------------------------------
`define IRF_FRAME_BITS    22
`define IRF_LAST_BIT      5'h15
`define IRF_CUST_HI       21
`define IRF_CUST_LO       17
`define IRF_DATA_HI       16
`define IRF_DATA_LO       11
`define IRF_NCUST_HI      10
`define IRF_NCUST_LO      6
`define IRF_NDATA_HI      5
`define IRF_NDATA_LO      0

// ------------------------------------------------------------
// Toggle-protocol frame: start, toggle, 4 address, 7 command
// ------------------------------------------------------------
`define IRF_TGL_BITS      13
`define IRF_TGL_START     12
`define IRF_TGL_TOGGLE    11
`define IRF_TGL_ADR_HI    10
`define IRF_TGL_ADR_LO    7
`define IRF_TGL_CMD_HI    6
`define IRF_TGL_CMD_LO    0

// ------------------------------------------------------------
// Output packing
// ------------------------------------------------------------
`define IRF_BUF_W         24
`define IRF_BYTES_2       2'h2
`define IRF_BYTES_3       2'h3
`define IRF_START_BIT     1'h1
`define IRF_TOGGLE_BIT    1'h0
`define IRF_SYNC_MARK     1'h1
`define IRF_NO_ADDR5      5'h00
`define IRF_NO_ADDR4      4'h0

`endif

// ==== logic/irf_byte_shifter.v ====
// Byte shifter that drives formatted remote-control bytes onto the
// serial data line. Expects load and shift strobes from the serial bus
// logic on the same clock.
`timescale 1ns/10ps

module irf_byte_shifter (
  input  wire       i_core_clk, // Core clock
  input  wire       i_nrst,     // Async reset, active low
  input  wire       i_load,     // Load a new byte
  input  wire [7:0] i_byte,     // Byte to load
  input  wire       i_shift,    // Advance one bit
  output wire       o_bit       // Current serial bit
);

  reg [7:0] shift_reg;

  // ------------------------------------------------------------
  // Shift register, idle line reads as one
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_reg <= 8'hff;
    end else if (i_load) begin
      shift_reg <= i_byte;
    end else if (i_shift) begin
      shift_reg <= {shift_reg[6:0], 1'h1};
    end
  end

  assign o_bit = shift_reg[7];

endmodule

// ==== logic/irf_frame_formatter.v ====
// Infrared remote frame formatter: decodes complemented-code frames from
// the photodiode input, accepts toggle-protocol frames, and packs bytes.
// Assumes the receiver input is asynchronous; bus logic gives strobes.
`timescale 1ns/10ps
`include "irf_map.vh"

module irf_frame_formatter #(
  parameter T_CYC = `IRF_BASE_T_NS / `IRF_CLK_NS // Cycles per base period
) (
  input  wire        i_core_clk,               // Core clock, 40 MHz
  input  wire        i_nrst,                   // Async reset, active low
  input  wire        i_infrared_receive_input, // Photodiode output, async
  input  wire        i_raw_format,             // 1 raw, 0 decoded
  input  wire        i_tgl_valid,              // Toggle-protocol frame strobe
  input  wire [12:0] i_tgl_bits,               // Toggle-protocol frame bits
  input  wire        i_byte_load,              // Next byte to shifter
  input  wire        i_bit_shift,              // Next serial bit
  output wire        o_serial_bit,             // Serial data bit
  output reg         o_data_avail,             // Bytes waiting
  output reg         o_key_held,               // Repeat frames seen
  output reg         o_frame_drop              // Frame discarded pulse
);

  localparam integer T_LAST_I = T_CYC - 1;
  localparam [14:0]  T_LAST   = T_LAST_I[14:0];

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SON  = 3'h1;
  localparam [2:0] ST_SOFF = 3'h2;
  localparam [2:0] ST_BON  = 3'h3;
  localparam [2:0] ST_BOFF = 3'h4;

  localparam integer GAP_LO_I = `IRF_FRAME_T - `IRF_FRAME_TOL;
  localparam integer GAP_HI_I = `IRF_FRAME_T + `IRF_FRAME_TOL;
  localparam [`IRF_GAP_W-1:0] GAP_LO  = GAP_LO_I[`IRF_GAP_W-1:0];
  localparam [`IRF_GAP_W-1:0] GAP_HI  = GAP_HI_I[`IRF_GAP_W-1:0];
  localparam [`IRF_GAP_W-1:0] GAP_SAT = {`IRF_GAP_W{1'b1}};

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  reg meta_reg;
  reg sync_reg;
  reg carrier_reg;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg    <= 1'h1;
      sync_reg    <= 1'h1;
      carrier_reg <= 1'h0;
    end else begin
      meta_reg    <= i_infrared_receive_input;
      sync_reg    <= meta_reg;
      carrier_reg <= ~sync_reg;
    end
  end

  wire carrier_on = ~sync_reg;
  wire rise       = carrier_on & ~carrier_reg;
  wire fall       = ~carrier_on & carrier_reg;
  wire edge_seen  = rise | fall;

  // ------------------------------------------------------------
  // Segment length in base periods
  // ------------------------------------------------------------
  reg  [14:0]             presc_reg;
  reg  [`IRF_UNIT_W-1:0]  units_reg;
  wire                    tick = (presc_reg == T_LAST);

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_reg <= 15'h0000;
      units_reg <= {`IRF_UNIT_W{1'b0}};
    end else if (edge_seen) begin
      presc_reg <= 15'h0000;
      units_reg <= {`IRF_UNIT_W{1'b0}};
    end else if (tick) begin
      presc_reg <= 15'h0000;
      if (units_reg != `IRF_UNIT_SAT) begin
        units_reg <= units_reg + 1'b1;
      end
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  function in_rng;
    input [`IRF_UNIT_W-1:0] len;
    input [`IRF_UNIT_W-1:0] lo;
    input [`IRF_UNIT_W-1:0] hi;
    begin
      in_rng = (len >= lo) && (len <= hi);
    end
  endfunction

  wire sync_len = in_rng(units_reg, `IRF_SYNC_LO, `IRF_SYNC_HI);
  wire mark_len = in_rng(units_reg, `IRF_ON_LO, `IRF_ON_HI);
  wire zero_len = in_rng(units_reg, `IRF_ZERO_LO, `IRF_ZERO_HI);
  wire one_len  = in_rng(units_reg, `IRF_ONE_LO, `IRF_ONE_HI);

  // ------------------------------------------------------------
  // Frame receiver
  // ------------------------------------------------------------
  reg  [2:0]                  state_reg;
  reg  [2:0]                  state_next;
  reg  [`IRF_FRAME_BITS-1:0]  bits_reg;
  reg  [4:0]                  bitcnt_reg;
  reg                         done_reg;

  wire bit_ok   = rise & (zero_len | one_len);
  wire timeout  = (units_reg == `IRF_UNIT_SAT);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (rise) state_next = ST_SON;
      ST_SON: begin
        if (fall) state_next = sync_len ? ST_SOFF : ST_IDLE;
      end
      ST_SOFF: begin
        if (rise) state_next = sync_len ? ST_BON : ST_IDLE;
      end
      ST_BON: begin
        if (fall) state_next = mark_len ? ST_BOFF : ST_IDLE;
      end
      ST_BOFF: begin
        if (rise) begin
          if (!bit_ok || bitcnt_reg == `IRF_LAST_BIT) state_next = ST_IDLE;
          else state_next = ST_BON;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (timeout && state_reg != ST_IDLE) state_next = ST_IDLE;
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg  <= ST_IDLE;
      bits_reg   <= {`IRF_FRAME_BITS{1'b0}};
      bitcnt_reg <= 5'h00;
      done_reg   <= 1'h0;
    end else begin
      state_reg <= state_next;
      done_reg  <= 1'h0;
      if (state_reg == ST_SOFF) begin
        bitcnt_reg <= 5'h00;
      end
      if (state_reg == ST_BOFF && bit_ok && !timeout) begin
        bits_reg   <= {bits_reg[`IRF_FRAME_BITS-2:0], one_len};
        bitcnt_reg <= bitcnt_reg + 1'b1;
        done_reg   <= (bitcnt_reg == `IRF_LAST_BIT);
      end
    end
  end

  // ------------------------------------------------------------
  // Field checks
  // ------------------------------------------------------------
  wire [4:0] cust   = bits_reg[`IRF_CUST_HI:`IRF_CUST_LO];
  wire [5:0] data   = bits_reg[`IRF_DATA_HI:`IRF_DATA_LO];
  wire       comp_ok = (bits_reg[`IRF_NCUST_HI:`IRF_NCUST_LO] == ~cust) &&
                       (bits_reg[`IRF_NDATA_HI:`IRF_NDATA_LO] == ~data);
  wire       cc_keep = comp_ok && (i_raw_format || cust == `IRF_NO_ADDR5);

  wire [3:0] t_adr = i_tgl_bits[`IRF_TGL_ADR_HI:`IRF_TGL_ADR_LO];
  wire [6:0] t_cmd = i_tgl_bits[`IRF_TGL_CMD_HI:`IRF_TGL_CMD_LO];
  wire       t_keep = i_raw_format || t_adr == `IRF_NO_ADDR4;

  // Padded ones fill the tail of every packed frame
  wire [`IRF_BUF_W-1:0] cc_raw = {`IRF_SYNC_MARK, bits_reg, 1'b1};
  wire [`IRF_BUF_W-1:0] cc_dec = {cust, `IRF_START_BIT, `IRF_TOGGLE_BIT,
                                  data, 11'h7ff};
  wire [`IRF_BUF_W-1:0] t_raw  = {i_tgl_bits, 11'h7ff};
  wire [`IRF_BUF_W-1:0] t_dec  = {t_adr, i_tgl_bits[`IRF_TGL_START],
                                  i_tgl_bits[`IRF_TGL_TOGGLE], t_cmd, 11'h7ff};

  // ------------------------------------------------------------
  // Output buffer; a kept frame replaces unread bytes
  // ------------------------------------------------------------
  reg [`IRF_BUF_W-1:0] buf_reg;
  reg [1:0]            left_reg;
  wire                 take = i_byte_load && left_reg != 2'h0;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      buf_reg      <= {`IRF_BUF_W{1'b1}};
      left_reg     <= 2'h0;
      o_data_avail <= 1'h0;
      o_frame_drop <= 1'h0;
    end else begin
      o_frame_drop <= 1'h0;
      if (done_reg) begin
        if (cc_keep) begin
          buf_reg  <= i_raw_format ? cc_raw : cc_dec;
          left_reg <= i_raw_format ? `IRF_BYTES_3 : `IRF_BYTES_2;
        end else begin
          o_frame_drop <= 1'h1;
          if (take) begin
            buf_reg  <= {buf_reg[`IRF_BUF_W-9:0], 8'hff};
            left_reg <= left_reg - 1'b1;
          end
        end
      end else if (i_tgl_valid) begin
        if (t_keep) begin
          buf_reg  <= i_raw_format ? t_raw : t_dec;
          left_reg <= `IRF_BYTES_2;
        end else begin
          o_frame_drop <= 1'h1;
          if (take) begin
            buf_reg  <= {buf_reg[`IRF_BUF_W-9:0], 8'hff};
            left_reg <= left_reg - 1'b1;
          end
        end
      end else if (take) begin
        buf_reg  <= {buf_reg[`IRF_BUF_W-9:0], 8'hff};
        left_reg <= left_reg - 1'b1;
      end
      o_data_avail <= (left_reg != 2'h0);
    end
  end

  // ------------------------------------------------------------
  // Repeat tracking: complemented-code frames 232T to 248T apart mean the key is held
  // ------------------------------------------------------------
  reg  [14:0]           gpresc_reg;
  reg  [`IRF_GAP_W-1:0] gap_reg;
  wire                  gap_tick = (gpresc_reg == T_LAST);
  wire                  cc_good  = done_reg && comp_ok;

  // Free-running base period: the edge prescaler restarts on every edge and loses time
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gpresc_reg <= 15'h0000;
    end else if (gap_tick) begin
      gpresc_reg <= 15'h0000;
    end else begin
      gpresc_reg <= gpresc_reg + 1'b1;
    end
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_reg    <= GAP_SAT;
      o_key_held <= 1'h0;
    end else if (cc_good) begin
      gap_reg    <= {`IRF_GAP_W{1'b0}};
      o_key_held <= (gap_reg >= GAP_LO) && (gap_reg <= GAP_HI);
    end else begin
      if (gap_tick && gap_reg != GAP_SAT) begin
        gap_reg <= gap_reg + 1'b1;
      end
      if (gap_reg > GAP_HI) begin
        o_key_held <= 1'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial output; host fetches after its 0x62 read command
  // ------------------------------------------------------------
  irf_byte_shifter u_shift (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_load     (take),
    .i_byte     (buf_reg[`IRF_BUF_W-1:`IRF_BUF_W-8]),
    .i_shift    (i_bit_shift),
    .o_bit      (o_serial_bit)
  );

endmodule

// ==== test/irf_frame_formatter_assertions.sv ====
// Port checker for irf_frame_formatter, bound into every instance.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module irf_frame_formatter_assertions #(
  parameter T_CYC = 17440 // Cycles per base period
) (
  input wire        i_core_clk,               // Clock
  input wire        i_nrst,                   // Reset
  input wire        i_infrared_receive_input, // Receiver
  input wire        i_raw_format,             // Format
  input wire        i_tgl_valid,              // Strobe
  input wire [12:0] i_tgl_bits,               // Frame
  input wire        i_byte_load,              // Load
  input wire        i_bit_shift,              // Shift
  input wire        o_serial_bit,             // Serial bit
  input wire        o_data_avail,             // Pending
  input wire        o_key_held,               // Repeat
  input wire        o_frame_drop              // Drop
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // Receiver activity age
  // ----------------------------------------
  // Frames complete only a few cycles after the trailing mark begins
  reg [7:0] lo_age_reg;
  always @(posedge i_core_clk or negedge i_nrst)
    if (!i_nrst)
      lo_age_reg <= 8'hff;
    else if (!i_infrared_receive_input)
      lo_age_reg <= 8'h00;
    else if (lo_age_reg != 8'hff)
      lo_age_reg <= lo_age_reg + 8'h01;
  a_drop_one_cycle:
    assert property (o_frame_drop |=> !o_frame_drop) else $error("drop pulse too long");
  a_drop_has_cause:
    assert property (o_frame_drop |-> lo_age_reg < 8'h10 || $past(i_tgl_valid) || $past(i_tgl_valid, 2))
    else $error("drop without a frame");
  a_avail_has_cause:
    assert property ($rose(o_data_avail) |-> lo_age_reg < 8'h10 || $past(i_tgl_valid, 2))
    else $error("data without a frame");
  a_tgl_accept:
    assert property (i_tgl_valid && !i_byte_load && (i_raw_format || i_tgl_bits[10:7] == 4'h0) |-> ##2 o_data_avail)
    else $error("toggle frame not buffered");
  a_tgl_addr_drop:
    assert property (i_tgl_valid && !i_raw_format && i_tgl_bits[10:7] != 4'h0 |-> ##[1:2] o_frame_drop)
    else $error("foreign address not dropped");
  a_serial_still:
    assert property (!i_byte_load && !i_bit_shift |=> $stable(o_serial_bit)) else $error("serial bit moved");
  a_shift_fills_ones:
    assert property (i_byte_load ##1 (i_bit_shift && !i_byte_load) [*8] |=> o_serial_bit)
    else $error("emptied shifter not high");
  a_avail_stands:
    assert property (o_data_avail && !i_byte_load && !$past(i_byte_load) |=> o_data_avail)
    else $error("pending data lost");
endmodule

bind irf_frame_formatter irf_frame_formatter_assertions #(.T_CYC(T_CYC)) u_irf_frame_formatter_assertions (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_infrared_receive_input(i_infrared_receive_input),
  .i_raw_format(i_raw_format), .i_tgl_valid(i_tgl_valid), .i_tgl_bits(i_tgl_bits), .i_byte_load(i_byte_load),
  .i_bit_shift(i_bit_shift), .o_serial_bit(o_serial_bit), .o_data_avail(o_data_avail),
  .o_key_held(o_key_held), .o_frame_drop(o_frame_drop));

// ==== test/irf_ir_sender.sv ====
// Photodiode receiver model: one complemented-code frame per go strobe.
// Assumes the word is held steady until the frame has been sent.
`timescale 1ns/10ps
module irf_ir_sender #(
  parameter int T = 20 // Cycles per base period
) (
  input  wire logic        i_clk,  // Clock
  input  wire logic        i_go,   // Start a frame
  input  wire logic [21:0] i_word, // First sent bit at the top
  output logic             o_ir,   // Low while carrier is on
  output logic             o_busy  // High while a frame is sent
);
  // ----------------------------------------
  // Waveform
  // ----------------------------------------
  initial o_ir = 1'h1;
  initial o_busy = 1'h0;
  task automatic seg(input logic on, input int n);
    o_ir <= ~on;
    repeat (n * T) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (i_go) begin
      o_busy <= 1'h1;
      seg(1'h1, 8);
      seg(1'h0, 8);
      for (int i = 21; i >= 0; i--) begin
        seg(1'h1, 2);
        seg(1'h0, i_word[i] ? 6 : 2);
      end
      seg(1'h1, 2);
      o_ir <= 1'h1;
      o_busy <= 1'h0;
    end
  end
endmodule

// ==== test/irf_frame_formatter_bench.sv ====
// Self-checking bench for irf_frame_formatter with a receiver model.
// Assumes a 40 MHz clock and a shortened base period.
`timescale 1ns/10ps
module irf_frame_formatter_bench;
  localparam int TC = 20;
  logic        clk = 1'h0, nrst = 1'h0, raw = 1'h0, tv = 1'h0, ld = 1'h0, sh = 1'h0, go = 1'h0;
  logic [12:0] tb = 13'h0000;
  logic [21:0] w = 22'h000000;
  wire         ir, sbit, avail, held, drop, busy;
  int          err_total = 0, compares = 0;
  always #12.5 clk = ~clk;
  irf_ir_sender #(.T(TC)) u_irf_ir_sender (.i_clk(clk), .i_go(go), .i_word(w), .o_ir(ir), .o_busy(busy));
  irf_frame_formatter #(.T_CYC(TC)) u_irf_frame_formatter (
    .i_core_clk(clk), .i_nrst(nrst), .i_infrared_receive_input(ir), .i_raw_format(raw),
    .i_tgl_valid(tv), .i_tgl_bits(tb), .i_byte_load(ld), .i_bit_shift(sh),
    .o_serial_bit(sbit), .o_data_avail(avail), .o_key_held(held), .o_frame_drop(drop));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Sel 0 pending bytes, 1 drop pulse, 2 sender busy, 3 sender idle; looks before waiting
  // so that a one-cycle drop raised at the request edge is not missed
  task automatic wait_for(input logic [1:0] sel);
    for (int i = 0; i < 5000; i++) begin
      #1;
      if ((sel == 2'h0 ? avail : sel == 2'h1 ? drop : sel == 2'h2 ? busy : ~busy) === 1'h1)
        return;
      @(posedge clk);
    end
    chk(24'h0, 24'h1);
    results();
  endtask
  // Go is held until the sender has taken it; the sender ignores it during a trailing mark
  task automatic pulse(input logic [21:0] word, input logic f);
    @(posedge clk);
    wait_for(2'h3);
    @(posedge clk);
    w <= word;
    raw <= f;
    go <= 1'h1;
    wait_for(2'h2);
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic send(input logic [21:0] word, input logic f, input logic sel);
    pulse(word, f);
    wait_for(sel);
  endtask
  task automatic tgl(input logic [12:0] b, input logic f, input logic sel);
    @(posedge clk);
    tb <= b;
    raw <= f;
    tv <= 1'h1;
    @(posedge clk);
    tv <= 1'h0;
    wait_for(sel);
  endtask
  // Reads n bytes, e holds them right-aligned, first byte on top
  task automatic rd(input logic [23:0] e, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      ld <= 1'h1;
      @(posedge clk);
      ld <= 1'h0;
      sh <= 1'h1;
      for (int i = 7; i >= 0; i--) begin
        #1 chk(sbit, e[8 * (n - k) - 8 + i]);
        @(posedge clk);
      end
      sh <= 1'h0;
    end
    #1 chk(avail, 1'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_decoded;
    send({5'h00, 6'h2a, 5'h1f, 6'h15}, 1'h0, 1'h0);
    rd({5'h00, 1'h1, 1'h0, 6'h2a, 3'h7}, 2);
    $display("decoded frame test done");
  endtask
  task automatic t_raw;
    logic [21:0] x = {5'h18, 6'h2a, 5'h07, 6'h15};
    send(x, 1'h1, 1'h0);
    rd({1'h1, x, 1'h1}, 3);
    $display("raw frame test done");
  endtask
  task automatic t_drop;
    send({5'h00, 6'h2a, 5'h1f, 6'h14}, 1'h0, 1'h1);
    repeat (4) @(posedge clk);
    #1 chk(avail, 1'h0);
    send({5'h18, 6'h2a, 5'h07, 6'h15}, 1'h0, 1'h1);
    $display("discard test done");
  endtask
  task automatic t_tgl;
    logic [12:0] a = {1'h1, 1'h1, 4'h0, 7'h54};
    logic [12:0] c = {1'h1, 1'h0, 4'hd, 7'h2a};
    tgl(a, 1'h0, 1'h0);
    rd({a[10:7], a[12], a[11], a[6:0], 3'h7}, 2);
    tgl(c, 1'h1, 1'h0);
    rd({c, 3'h7}, 2);
    tgl(c, 1'h0, 1'h1);
    $display("toggle frame test done");
  endtask
  task automatic t_key;
    logic [21:0] x = {5'h00, 6'h11, 5'h1f, 6'h2e};
    time         t0;
    pulse(x, 1'h0);
    t0 = $time;
    wait_for(2'h0);
    rd({5'h00, 1'h1, 1'h0, 6'h11, 3'h7}, 2);
    repeat (240 * TC - 2 - int'(($time - t0) / 25)) @(posedge clk);
    send(x, 1'h0, 1'h0);
    repeat (2) @(posedge clk);
    #1 chk(held, 1'h1);
    repeat (260 * TC) @(posedge clk);
    #1 chk(held, 1'h0);
    $display("repeat frame test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    t_decoded();
    t_raw();
    t_drop();
    t_tgl();
    t_key();
    results();
  end
endmodule
